// [wdt_supervisor_defines.vh]
// Constants for the watchdog and reset supervisor
`ifndef WDT_SUPERVISOR_DEFINES_VH
`define WDT_SUPERVISOR_DEFINES_VH
// Clock period in picoseconds (200 MHz)
`define CLK_PERIOD_PS 5000
// Kick window time in microseconds (nominal minimum window)
`define KICK_WINDOW_TIME_US 6250
// Power-up hold time in microseconds (same RC network as the window)
`define POWER_UP_HOLD_TIME_US 6250
// Derived cycle counts; cycles per microsecond first, so no product overflows 32 bits
`define KICK_WINDOW_CYCLES (`KICK_WINDOW_TIME_US * (1000000 / `CLK_PERIOD_PS))
`define POWER_UP_HOLD_CYCLES (`POWER_UP_HOLD_TIME_US * (1000000 / `CLK_PERIOD_PS))
// Reset values: kick pin idles high, linear output taken as low until measured
`define KICK_IDLE_LEVEL 1'h1
`define ABOVE_UPPER_RESET_VALUE 1'h0
`define BELOW_LOWER_RESET_VALUE 1'h1
`define ENABLE_RESET_VALUE 1'h0
`define SELECT_RESET_VALUE 1'h1
`define RESET_OUT_RESET_VALUE 1'h0
// Counter width
`define TIMER_WIDTH 32
`endif

// [watchdog_reset_supervisor.v]
// Watchdog kick monitor, undervoltage reset and regulator control pass-through
// Overview of operation
// - Only a falling edge on the kick input counts as service.
// - Kick window is one configurable timeout count derived from the RC time.
// - Missed kick starts repeated reset pulses until a valid kick arrives.
// - Pulse train is 50% square wave, each phase one kick window long.
// - Reset held low while linear output is below its regulation limit.
// - After recovery, reset stays low for the power-up hold time.
// - Hold interval starts when the upper comparator reports output above threshold.
// - Reset asserts at once when the lower comparator reports output too low.
// - Enable input high shuts the switching regulator down, low lets it run.
// - Select open or high picks feedback two, low picks feedback one.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_supervisor_defines.vh"

module watchdog_reset_supervisor #(
  parameter [`TIMER_WIDTH-1:0] KICK_WINDOW_CYCLES = `KICK_WINDOW_CYCLES,
  parameter [`TIMER_WIDTH-1:0] POWER_UP_HOLD_CYCLES = `POWER_UP_HOLD_CYCLES
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Pin inputs from the host
  input wire i_watchdog_kick_in,
  input wire i_enable,
  input wire i_select,
  // Comparator results on the linear output
  input wire i_lin_above_upper,
  input wire i_lin_below_lower,
  // Outputs
  output reg o_reset_n,
  output reg o_switcher_shutdown,
  output reg o_sel_feedback_two
);

  localparam [2:0] ST_UNDERVOLT = 3'h1;
  localparam [2:0] ST_HOLD = 3'h2;
  localparam [2:0] ST_RUN = 3'h4;

  // Terminal test used by both hold and window timers
  function expired;
    input [`TIMER_WIDTH-1:0] cnt;
    input [`TIMER_WIDTH-1:0] lim;
    begin
      expired = (cnt >= lim - 32'h00000001);
    end
  endfunction

  // Next filtered level: follows stage three once stages two and three agree
  function settle;
    input [2:0] sync;
    input lvl;
    begin
      if (sync[1] == sync[2])
        settle = sync[2];
      else
        settle = lvl;
    end
  endfunction

  reg [2:0] kick_sync_r;
  reg [2:0] en_sync_r;
  reg [2:0] sel_sync_r;
  reg [2:0] up_sync_r;
  reg [2:0] lo_sync_r;
  reg kick_lvl_r;
  reg en_lvl_r;
  reg sel_lvl_r;
  reg up_lvl_r;
  reg lo_lvl_r;
  reg kick_prev_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [`TIMER_WIDTH-1:0] cnt_r;
  reg [`TIMER_WIDTH-1:0] cnt_nxt;
  reg train_r;
  reg train_nxt;
  reg reset_n_nxt;
  wire kick_fall;

  // Kick pin synchroniser; starts at the idle level so no false kick follows reset
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      kick_sync_r <= {3{`KICK_IDLE_LEVEL}};
      kick_lvl_r <= `KICK_IDLE_LEVEL;
    end else begin
      kick_sync_r <= {kick_sync_r[1:0], i_watchdog_kick_in};
      kick_lvl_r <= settle(kick_sync_r, kick_lvl_r);
    end
  end

  // Enable pin synchroniser; regulator allowed to run until a level is seen
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_sync_r <= {3{`ENABLE_RESET_VALUE}};
      en_lvl_r <= `ENABLE_RESET_VALUE;
    end else begin
      en_sync_r <= {en_sync_r[1:0], i_enable};
      en_lvl_r <= settle(en_sync_r, en_lvl_r);
    end
  end

  // Select pin synchroniser; starts as the open pin, which picks feedback two
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_sync_r <= {3{`SELECT_RESET_VALUE}};
      sel_lvl_r <= `SELECT_RESET_VALUE;
    end else begin
      sel_sync_r <= {sel_sync_r[1:0], i_select};
      sel_lvl_r <= settle(sel_sync_r, sel_lvl_r);
    end
  end

  // Upper comparator synchroniser; output not yet taken as recovered
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      up_sync_r <= {3{`ABOVE_UPPER_RESET_VALUE}};
      up_lvl_r <= `ABOVE_UPPER_RESET_VALUE;
    end else begin
      up_sync_r <= {up_sync_r[1:0], i_lin_above_upper};
      up_lvl_r <= settle(up_sync_r, up_lvl_r);
    end
  end

  // Lower comparator synchroniser; output taken as too low until measured
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lo_sync_r <= {3{`BELOW_LOWER_RESET_VALUE}};
      lo_lvl_r <= `BELOW_LOWER_RESET_VALUE;
    end else begin
      lo_sync_r <= {lo_sync_r[1:0], i_lin_below_lower};
      lo_lvl_r <= settle(lo_sync_r, lo_lvl_r);
    end
  end

  // Falling-edge detect on the filtered kick level
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      kick_prev_r <= 1'b1;
    end else begin
      kick_prev_r <= kick_lvl_r;
    end
  end

  assign kick_fall = kick_prev_r & ~kick_lvl_r;

  // Supervisor state machine and shared timer
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 32'h00000001;
    train_nxt = train_r;
    reset_n_nxt = 1'b0;
    case (state_r)
      ST_UNDERVOLT: begin
        cnt_nxt = {`TIMER_WIDTH{1'b0}};
        train_nxt = 1'b1;
        if (up_lvl_r && !lo_lvl_r) begin
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        train_nxt = 1'b1;
        if (lo_lvl_r) begin
          state_nxt = ST_UNDERVOLT;
        end else if (expired(cnt_r, POWER_UP_HOLD_CYCLES)) begin
          state_nxt = ST_RUN;
          cnt_nxt = {`TIMER_WIDTH{1'b0}};
          reset_n_nxt = 1'b1;
        end
      end
      ST_RUN: begin
        reset_n_nxt = train_r;
        if (lo_lvl_r) begin
          state_nxt = ST_UNDERVOLT;
          reset_n_nxt = 1'b0;
        end else if (kick_fall) begin
          cnt_nxt = {`TIMER_WIDTH{1'b0}};
          train_nxt = 1'b1;
          reset_n_nxt = 1'b1;
        end else if (expired(cnt_r, KICK_WINDOW_CYCLES)) begin
          cnt_nxt = {`TIMER_WIDTH{1'b0}};
          train_nxt = ~train_r;
          reset_n_nxt = ~train_r;
        end
      end
      default: begin
        state_nxt = ST_UNDERVOLT;
        cnt_nxt = {`TIMER_WIDTH{1'b0}};
        train_nxt = 1'b1;
      end
    endcase
  end

  // State, timer and registered reset output
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_UNDERVOLT;
      cnt_r <= {`TIMER_WIDTH{1'b0}};
      train_r <= 1'b1;
      o_reset_n <= `RESET_OUT_RESET_VALUE;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      train_r <= train_nxt;
      o_reset_n <= reset_n_nxt;
    end
  end

  // Regulator controls follow the filtered pins, one flop from the output pins
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_switcher_shutdown <= `ENABLE_RESET_VALUE;
      o_sel_feedback_two <= `SELECT_RESET_VALUE;
    end else begin
      o_switcher_shutdown <= en_lvl_r;
      o_sel_feedback_two <= sel_lvl_r;
    end
  end

endmodule // watchdog_reset_supervisor
`default_nettype wire

// [wdt_checker.sv]
// Checker for the supervisor outputs
`timescale 1ns/1ps
`default_nettype none
module wdt_checker #(parameter KICK_WINDOW_CYCLES = 20, parameter POWER_UP_HOLD_CYCLES = 30) (
  input wire i_clk, i_rst_n, i_watchdog_kick_in, i_enable, i_select,
  input wire i_lin_above_upper, i_lin_below_lower,
  input wire o_reset_n, o_switcher_shutdown, o_sel_feedback_two);
  int hi;
  int due;
  // Length of the high phase and cycles since the last kick
  always @(posedge i_clk) begin
    hi <= o_reset_n ? hi + 1 : 0;
    due <= (!o_reset_n || $fell(i_watchdog_kick_in)) ? 0 : due + 1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  shut_follow_a: assert property ($stable(i_enable)[*5] |-> o_switcher_shutdown == i_enable)
    else $error("shutdown differs from enable");
  sel_follow_a: assert property ($stable(i_select)[*5] |-> o_sel_feedback_two == i_select)
    else $error("feedback select differs");
  uv_low_a: assert property (i_lin_below_lower[*6] |-> !o_reset_n)
    else $error("reset high in undervoltage");
  uv_hold_a: assert property ($fell(i_lin_below_lower) |-> (!o_reset_n)[*8])
    else $error("hold too short");
  kick_due_a: assert property (o_reset_n |-> due <= KICK_WINDOW_CYCLES + 8)
    else $error("missed kick gave no reset");
  train_high_a: assert property ($fell(o_reset_n) && !i_lin_below_lower
    && !$past(i_lin_below_lower, 8) |-> hi >= KICK_WINDOW_CYCLES - 1)
    else $error("high phase too short");
  rise_ok_a: assert property ($rose(o_reset_n) |-> !$past(i_lin_below_lower, 6))
    else $error("reset released while low");
  reset_vals_a: assert property (disable iff (1'b0) !i_rst_n |-> !o_reset_n
    && o_sel_feedback_two && !o_switcher_shutdown)
    else $error("wrong values in reset");
endmodule // wdt_checker
bind watchdog_reset_supervisor wdt_checker #(.KICK_WINDOW_CYCLES(KICK_WINDOW_CYCLES),
  .POWER_UP_HOLD_CYCLES(POWER_UP_HOLD_CYCLES)) wdt_checker_inst (.i_clk, .i_rst_n,
  .i_watchdog_kick_in, .i_enable, .i_select, .i_lin_above_upper, .i_lin_below_lower,
  .o_reset_n, .o_switcher_shutdown, .o_sel_feedback_two);
`default_nettype wire

// [host_model.sv]
// Host model that services the watchdog
`timescale 1ns/1ps
`default_nettype none
module host_model (input wire logic i_clk, input wire logic i_kick_on, output logic o_kick);
  logic [2:0] c = 3'h0;
  initial o_kick = 1'b1;
  // Toggle every 8 cycles, a falling kick each 16; off holds the level
  always @(negedge i_clk) begin
    if (i_kick_on) begin
      c <= c + 3'h1;
      if (c == 3'h7) o_kick <= ~o_kick;
    end
  end
endmodule // host_model
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the supervisor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
  $display("wrong value at %0t: %h vs %h", $time, a, e); end end
module tb_top;
  localparam int KW = 20;
  localparam int HOLD = 30;
  logic i_clk = 1'b0, i_rst_n = 1'b1, en = 1'b0, sel = 1'b1;
  logic above = 1'b0, below = 1'b1, kon = 1'b1;
  wire kick, o_reset_n, shut, fb2;
  int err_total = 0, n_tests = 0, cyc = 0, n, i;
  always #2.5 i_clk = ~i_clk;
  host_model host_model_inst (.i_clk(i_clk), .i_kick_on(kon), .o_kick(kick));
  watchdog_reset_supervisor #(.KICK_WINDOW_CYCLES(KW), .POWER_UP_HOLD_CYCLES(HOLD))
    watchdog_reset_supervisor_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_watchdog_kick_in(kick), .i_enable(en), .i_select(sel), .i_lin_above_upper(above),
    .i_lin_below_lower(below), .o_reset_n(o_reset_n), .o_switcher_shutdown(shut),
    .o_sel_feedback_two(fb2));
  task end_sim;
    if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 1000) begin err_total++; end_sim; end
  end
  // Count falling edges while the reset output holds level v
  task hold_while(input logic v);
    n = 0;
    while (o_reset_n === v && n < 90) begin @(negedge i_clk); n++; end
  endtask
  task t_power;
    repeat (10) @(negedge i_clk);
    `CHK(o_reset_n, 1'b0)
    below = 1'b0;
    above = 1'b1;
    hold_while(1'b0);
    `CHK(n >= HOLD && n <= HOLD + 8, 1'b1)
  endtask
  task t_kick;
    kon = 1'b1;
    repeat (30) @(negedge i_clk);
    for (i = 0; i < 100; i++) begin @(negedge i_clk); `CHK(o_reset_n, 1'b1) end
  endtask
  task t_train;
    kon = 1'b0;
    hold_while(1'b1);
    hold_while(1'b0);
    `CHK(n, KW)
    hold_while(1'b1);
    `CHK(n, KW)
  endtask
  task t_uv;
    below = 1'b1;
    repeat (8) @(negedge i_clk);
    `CHK(o_reset_n, 1'b0)
    repeat (50) @(negedge i_clk);
    `CHK(o_reset_n, 1'b0)
  endtask
  task t_pins;
    for (i = 0; i < 4; i++) begin
      {en, sel} = i[1:0];
      repeat (6) @(negedge i_clk);
      `CHK(shut, en)
      `CHK(fb2, sel)
    end
  endtask
  initial begin
    #1 i_rst_n = 1'b0;
    repeat (6) @(negedge i_clk);
    i_rst_n = 1'b1;
    t_power;
    t_kick;
    t_train;
    t_kick;
    t_uv;
    t_pins;
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
